// ### logic/gtm_pkg.sv
/*
  Shared constants and carrier types for the general timer block: register
  offsets, configuration and mode codes, reset values, status bit positions.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses in 8 bits.
*/
package gtm_pkg;

  // ==========================================================================
  // bus shape and register map
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MODE_A = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MODE_B = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_RAW = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_MASKED = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CLEAR = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_LOAD_A = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_LOAD_B = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_MATCH_A = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_MATCH_B = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_PRESCALE_A = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_PRESCALE_B = 8'h3C;
  localparam logic [ADDR_W-1:0] OFS_COUNT_A = 8'h48;
  localparam logic [ADDR_W-1:0] OFS_COUNT_B = 8'h4C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] STRB_FULL = 4'hF;

  // ==========================================================================
  // configuration, mode and event codes
  localparam logic [2:0] CFG_JOINED = 3'h0;
  localparam logic [2:0] CFG_CLOCK = 3'h1;
  localparam logic [2:0] CFG_SPLIT = 3'h4;
  localparam logic [1:0] MODE_ONESHOT = 2'h1;
  localparam logic [1:0] MODE_PERIODIC = 2'h2;
  localparam logic [1:0] MODE_CAPTURE = 2'h3;
  localparam logic [1:0] EV_RISE = 2'h0;
  localparam logic [1:0] EV_FALL = 2'h1;
  localparam logic [1:0] EV_BOTH = 2'h3;

  // ==========================================================================
  // reset values and field positions
  localparam logic [15:0] CNT_RESET = 16'hFFFF;
  localparam logic [15:0] LOAD_RESET = 16'hFFFF;
  localparam logic [7:0] PRE_RESET = 8'h00;
  localparam logic [31:0] CLOCK_FIRST = 32'h0000_0001;
  localparam int HALF_STRIDE = 8;
  localparam int ST_TIMEOUT = 0;
  localparam int ST_CAPMATCH = 1;
  localparam int ST_CLOCK = 3;
  localparam int CTL_RUN_DEBUG = 6;
  localparam int RTC_INPUT_HZ = 32768;
  localparam int RTC_STEP_HZ = 1;

  // ==========================================================================
  // carrier types
  typedef struct packed {
    logic adc_en;
    logic [1:0] event_sel;
    logic stall;
    logic enable;
  } gtm_half_ctl_type;

  typedef struct packed {
    logic capture_mode_bit;
    logic [1:0] mode_field;
  } gtm_half_mode_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [3:0] strb;
  } gtm_wreq_type;

endpackage : gtm_pkg

// ### logic/gtm_general_timer.sv
/*
  General timer: two 16-bit halves that join into one 32-bit down-counter or
  real-time-clock up-counter, or run apart as prescaled one-shot/periodic
  timers or edge counters. Registers over AXI4-Lite.
  Assumes capture pins and the debug halt level are synchronous to aclk.
*/
// Notes on behaviour
// - configuration 0 joins halves for timing, 1 selects clock mode, 0x4 splits them.
// - joined modes: full write of half A load also fills half B from upper bits.
// - joined modes: half A count read returns half B above half A.
// - joined timing mode: one 32-bit down-counter, one-shot or periodic from half A only.
// - counts down once enabled; at zero reloads next cycle; one-shot then self-disables.
// - joined zero sets held timeout flag, masked copy, and ADC trigger when enabled.
// - rewriting the load value while running is taken by the counter next cycle.
// - debug stall bit freezes the timer while the processor is halted.
// - clock mode counts up; first selection loads one; later values via half A match.
// - outside party supplies 32.768 kHz on the even pin; divided to 1 Hz steps.
// - clock count equal to match rolls to zero, runs until reset or disable.
// - clock match sets raw flag, masked flag and interrupt; cleared by its clear bit.
// - run-in-debug bit in clock mode overrides both halves' stall bits.
// - split mode: each half a 16-bit down-counter with 8-bit prescaler, mode from field.
// - half at zero reloads load and prescale next cycle; one-shot then self-disables.
// - half at zero sets its held timeout flag, masked flag, and optional ADC trigger.
// - each count step lasts prescale setting plus one clocks.
// - capture bit 0 selects edge counting; no prescaler; event field picks edges.
// - each selected edge decrements until equal to match; then capture-match flags set.
// - after match, reload from load, self-disable, ignore edges until re-enabled.
// - reset: counters and loads 0xFFFF, controls cleared, block inactive.
`timescale 1ns/1ps
module gtm_general_timer
  import gtm_pkg::*;
#(
  parameter int unsigned RTC_DIVIDE = RTC_INPUT_HZ / RTC_STEP_HZ
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write byte address
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  input wire logic [DATA_W-1:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  output logic [1:0] s_axi_bresp, // write response code
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read byte address
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic [DATA_W-1:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response code
  input wire logic [1:0] capture_compare_pin, // bit 0 even pin (half A), bit 1 odd
  input wire logic debug_halt, // processor halted by debugger
  output logic timer_irq, // any masked flag set
  output logic adc_trigger // one-cycle ADC trigger pulse
);

  localparam int DIV_W = (RTC_DIVIDE > 1) ? $clog2(RTC_DIVIDE) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(RTC_DIVIDE - 1);

  // ==========================================================================
  // state
  logic [2:0] cfg;
  gtm_half_mode_type mode [2];
  gtm_half_ctl_type ctl [2];
  logic run_in_debug;
  logic [DATA_W-1:0] mask;
  logic [DATA_W-1:0] raw;
  logic [15:0] load [2];
  logic [15:0] match [2];
  logic [7:0] prescale [2];
  logic [15:0] cnt [2];
  logic [7:0] pre_cnt [2];
  logic [1:0] reload_pend;
  logic [1:0] pin_prev;
  logic [DIV_W-1:0] rtc_div;
  logic rtc_seen;
  logic aw_got;
  logic w_got;
  gtm_wreq_type wq;

  // ==========================================================================
  // decode and events
  logic joined;
  logic clock_mode;
  logic split;
  logic wr_fire;
  logic full_word;
  logic [31:0] cnt32;
  logic [31:0] load32;
  logic [31:0] match32;
  logic [1:0] run;
  logic [1:0] edge_ev;
  logic [1:0] tmo;
  logic [1:0] capm;
  logic [1:0] hw_dis;
  logic rtc_step;
  logic rtcm;
  logic [DATA_W-1:0] stat_set;
  logic [DATA_W-1:0] next_raw;
  logic [DATA_W-1:0] rd_data;
  logic rd_ok;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic wsel(input logic fire, input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] ofs);
    return fire && (a == ofs);
  endfunction : wsel

  assign joined = (cfg == CFG_JOINED);
  assign clock_mode = (cfg == CFG_CLOCK);
  assign split = (cfg == CFG_SPLIT);
  assign wr_fire = aw_got && w_got && !s_axi_bvalid;
  assign full_word = (wq.strb == STRB_FULL);
  assign cnt32 = {cnt[1], cnt[0]};
  assign load32 = {load[1], load[0]};
  assign match32 = {match[1], match[0]};

  // freeze during a debug halt; in clock mode the run-in-debug bit wins
  always_comb begin
    run[1] = ctl[1].enable && !(debug_halt && ctl[1].stall);
    if (clock_mode) begin
      run[0] = ctl[0].enable
        && !(debug_halt && (ctl[0].stall || ctl[1].stall) && !run_in_debug);
    end else begin
      run[0] = ctl[0].enable && !(debug_halt && ctl[0].stall);
    end
  end

  // pins are sampled as synchronous inputs; the three-clock hold keeps edges apart
  genvar gh;
  generate
    for (gh = 0; gh < 2; gh++) begin : g_edge
      logic rise;
      logic fall;
      assign rise = capture_compare_pin[gh] && !pin_prev[gh];
      assign fall = !capture_compare_pin[gh] && pin_prev[gh];
      always_comb begin
        case (ctl[gh].event_sel)
          EV_RISE: edge_ev[gh] = rise;
          EV_FALL: edge_ev[gh] = fall;
          EV_BOTH: edge_ev[gh] = rise || fall;
          default: edge_ev[gh] = 1'b0;
        endcase
      end
    end
  endgenerate

  assign rtc_step = clock_mode && rtc_seen && run[0] && g_edge[0].rise
    && (rtc_div == DIV_LAST);
  assign rtcm = rtc_step && (cnt32 == match32);

  always_comb begin
    tmo = '0;
    capm = '0;
    hw_dis = '0;
    if (joined && !reload_pend[0] && run[0] && cnt32 == '0) begin
      tmo[0] = 1'b1;
      hw_dis[0] = (mode[0].mode_field == MODE_ONESHOT);
    end
    for (int h = 0; h < 2; h++) begin
      if (split && !reload_pend[h] && run[h]) begin
        if (mode[h].mode_field == MODE_CAPTURE && !mode[h].capture_mode_bit) begin
          if (cnt[h] == match[h]) begin
            capm[h] = 1'b1;
            hw_dis[h] = 1'b1;
          end
        end else if (mode[h].mode_field == MODE_ONESHOT
                     || mode[h].mode_field == MODE_PERIODIC) begin
          if (cnt[h] == '0 && pre_cnt[h] == '0) begin
            tmo[h] = 1'b1;
            hw_dis[h] = (mode[h].mode_field == MODE_ONESHOT);
          end
        end
      end
    end
  end

  always_comb begin
    stat_set = '0;
    for (int h = 0; h < 2; h++) begin
      stat_set[h*HALF_STRIDE + ST_TIMEOUT] = tmo[h];
      stat_set[h*HALF_STRIDE + ST_CAPMATCH] = capm[h];
    end
    stat_set[ST_CLOCK] = rtcm;
    next_raw = raw;
    if (wsel(wr_fire, wq.addr, OFS_CLEAR)) begin
      next_raw = raw & ~wq.data;
    end
    next_raw = next_raw | stat_set; // a new event beats a clear in the same cycle
  end

  // ==========================================================================
  // AXI4-Lite handshakes: one write and one read in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      wq <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_got <= 1'b1;
        wq.addr <= s_axi_awaddr;
      end else if (!aw_got && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_got <= 1'b1;
        wq.data <= s_axi_wdata;
        wq.strb <= s_axi_wstrb;
      end else if (!w_got && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_fire) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wq.addr inside {OFS_CONFIG, OFS_MODE_A, OFS_MODE_B, OFS_CONTROL,
          OFS_MASK, OFS_CLEAR, OFS_LOAD_A, OFS_LOAD_B, OFS_MATCH_A, OFS_MATCH_B,
          OFS_PRESCALE_A, OFS_PRESCALE_B}) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_ok = 1'b1;
    rd_data = '0;
    case (s_axi_araddr)
      OFS_CONFIG: rd_data[2:0] = cfg;
      OFS_MODE_A: rd_data[2:0] = mode[0];
      OFS_MODE_B: rd_data[2:0] = mode[1];
      OFS_CONTROL: begin
        rd_data[4:0] = ctl[0];
        rd_data[CTL_RUN_DEBUG] = run_in_debug;
        rd_data[HALF_STRIDE +: 5] = ctl[1];
      end
      OFS_MASK: rd_data = mask;
      OFS_RAW: rd_data = raw;
      OFS_MASKED: rd_data = raw & mask;
      OFS_CLEAR: rd_data = '0;
      OFS_LOAD_A: rd_data = (joined || clock_mode) ? load32 : {16'h0000, load[0]};
      OFS_LOAD_B: rd_data[15:0] = load[1];
      OFS_MATCH_A: rd_data = (joined || clock_mode) ? match32 : {16'h0000, match[0]};
      OFS_MATCH_B: rd_data[15:0] = match[1];
      OFS_PRESCALE_A: rd_data[7:0] = prescale[0];
      OFS_PRESCALE_B: rd_data[7:0] = prescale[1];
      OFS_COUNT_A: rd_data = (joined || clock_mode) ? cnt32 : {16'h0000, cnt[0]};
      OFS_COUNT_B: rd_data[15:0] = cnt[1];
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= CFG_JOINED;
      mode <= '{default: '0};
      mask <= '0;
      prescale <= '{default: PRE_RESET};
      match <= '{default: '0};
    end else if (ce) begin
      if (wsel(wr_fire, wq.addr, OFS_CONFIG)) cfg <= wq.data[2:0];
      if (wsel(wr_fire, wq.addr, OFS_MODE_A)) mode[0] <= wq.data[2:0];
      if (wsel(wr_fire, wq.addr, OFS_MODE_B)) mode[1] <= wq.data[2:0];
      if (wsel(wr_fire, wq.addr, OFS_MASK)) mask <= merge(mask, wq.data, wq.strb);
      if (wsel(wr_fire, wq.addr, OFS_PRESCALE_A)) prescale[0] <= wq.data[7:0];
      if (wsel(wr_fire, wq.addr, OFS_PRESCALE_B)) prescale[1] <= wq.data[7:0];
      if (wsel(wr_fire, wq.addr, OFS_MATCH_A)) begin
        if ((joined || clock_mode) && full_word) begin
          {match[1], match[0]} <= wq.data;
        end else begin
          match[0] <= wq.data[15:0];
        end
      end
      if (wsel(wr_fire, wq.addr, OFS_MATCH_B)) match[1] <= wq.data[15:0];
    end
  end

  // hardware clears of enable lose to a software write of the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl <= '{default: '0};
      run_in_debug <= 1'b0;
    end else if (ce) begin
      if (wsel(wr_fire, wq.addr, OFS_CONTROL)) begin
        ctl[0] <= wq.data[4:0];
        run_in_debug <= wq.data[CTL_RUN_DEBUG];
        ctl[1] <= wq.data[HALF_STRIDE +: 5];
      end else begin
        for (int h = 0; h < 2; h++) begin
          if (hw_dis[h]) ctl[h].enable <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load <= '{default: LOAD_RESET};
      reload_pend <= '0;
    end else if (ce) begin
      reload_pend <= '0;
      if (wsel(wr_fire, wq.addr, OFS_LOAD_A)) begin
        if ((joined || clock_mode) && full_word) begin
          {load[1], load[0]} <= wq.data;
          reload_pend <= 2'b11;
        end else begin
          load[0] <= wq.data[15:0];
          reload_pend[0] <= 1'b1;
        end
      end
      if (wsel(wr_fire, wq.addr, OFS_LOAD_B)) begin
        load[1] <= wq.data[15:0];
        reload_pend[1] <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raw <= '0;
      timer_irq <= 1'b0;
      adc_trigger <= 1'b0;
      pin_prev <= '0;
    end else if (ce) begin
      raw <= next_raw;
      timer_irq <= |(next_raw & mask);
      adc_trigger <= (tmo[0] && ctl[0].adc_en) || (tmo[1] && ctl[1].adc_en);
      pin_prev <= capture_compare_pin;
    end
  end

  // ==========================================================================
  // counters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= '{default: CNT_RESET};
      pre_cnt <= '{default: PRE_RESET};
      rtc_div <= '0;
      rtc_seen <= 1'b0;
    end else if (ce) begin
      if (clock_mode) begin
        if (!rtc_seen) begin
          {cnt[1], cnt[0]} <= CLOCK_FIRST;
          rtc_seen <= 1'b1;
        end else if (!run[0]) begin
          rtc_div <= '0;
        end else if (g_edge[0].rise) begin
          rtc_div <= (rtc_div == DIV_LAST) ? '0 : rtc_div + 1'b1;
          if (rtcm) begin
            {cnt[1], cnt[0]} <= '0;
          end else if (rtc_step) begin
            {cnt[1], cnt[0]} <= cnt32 + 32'h0000_0001;
          end
        end
      end else if (joined) begin
        if (reload_pend[0]) begin
          {cnt[1], cnt[0]} <= load32;
        end else if (tmo[0]) begin
          {cnt[1], cnt[0]} <= load32;
        end else if (run[0]) begin
          {cnt[1], cnt[0]} <= cnt32 - 32'h0000_0001;
        end
      end else if (split) begin
        for (int h = 0; h < 2; h++) begin
          if (reload_pend[h]) begin
            cnt[h] <= load[h];
            pre_cnt[h] <= prescale[h];
          end else if (tmo[h] || capm[h]) begin
            cnt[h] <= load[h];
            pre_cnt[h] <= prescale[h];
          end else if (run[h] && mode[h].mode_field == MODE_CAPTURE) begin
            if (!mode[h].capture_mode_bit && edge_ev[h]) begin
              cnt[h] <= cnt[h] - 16'h0001;
            end
          end else if (run[h]) begin
            if (pre_cnt[h] == '0) begin
              pre_cnt[h] <= prescale[h];
              cnt[h] <= cnt[h] - 16'h0001;
            end else begin
              pre_cnt[h] <= pre_cnt[h] - 8'h01;
            end
          end
        end
      end
    end
  end

endmodule : gtm_general_timer

// ### bench/gtm_pin_model.sv
/*
  Far-side model of the capture pins: counted edges and a reference clock.
  Assumes the bench calls its tasks just after a rising edge of aclk.
*/
`timescale 1ns/1ps
module gtm_pin_model (
  input wire logic aclk, // system clock
  output logic [1:0] pin // capture pins, idle low
);
  initial pin = 2'h0;
  // ======
  // edge source: each level held three clocks
  task automatic edges(input int n, input int b);
    repeat (n) begin
      pin[b] <= ~pin[b];
      repeat (3) @(posedge aclk);
    end
  endtask : edges
  // scaled reference clock, the divider parameter is shortened to match;
  // it stands still between calls
  task automatic rtc(input int n);
    edges(2 * n, 0);
  endtask : rtc
endmodule : gtm_pin_model

// ### bench/gtm_timer_monitor.sv
/*
  Port-level checker for the general timer: bus handshakes, flags, trigger.
  Assumes ce held high; bound to the design module below.
*/
`timescale 1ns/1ps
module gtm_timer_monitor
  import gtm_pkg::*;
#(
  parameter int unsigned RTC_DIVIDE = 32768
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic [1:0] s_axi_bresp, // b code
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic timer_irq, // interrupt
  input wire logic adc_trigger // trigger
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ======
  // assertions
  reset_idle_a: assert property ($rose(aresetn) |-> !timer_irq && !adc_trigger)
    else $error("output active after reset");
  // only a completed register write may drop a held flag
  irq_held_a: assert property (timer_irq |=> timer_irq || s_axi_bvalid)
    else $error("interrupt dropped without a write");
  adc_pulse_a: assert property (adc_trigger |=> !adc_trigger)
    else $error("trigger longer than one cycle");
  b_after_w_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response late");
  r_after_ar_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  aw_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("response repeated");
  cover property (adc_trigger);
  cover property ($rose(timer_irq));
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : gtm_timer_monitor

bind gtm_general_timer gtm_timer_monitor #(.RTC_DIVIDE(RTC_DIVIDE)) gtm_timer_monitor_i (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .timer_irq, .adc_trigger);

// ### bench/tb_general_timer_counting_modes.sv
/*
  Bench for the general timer: bus tasks, then joined, clock, split and edge runs.
  Assumes the pin model on the capture pins and the monitor bound in.
*/
`timescale 1ns/1ps
module tb_general_timer_counting_modes;
  import gtm_pkg::*;
  logic aclk, aresetn, ce, awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr, halt, irq, adc;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdata, rdat, v;
  logic [31:0] adc_n = '0, gap = '0, last_gap = '0;
  logic [1:0] bresp, rresp, pin;
  logic [3:0] ws;
  logic [1:0] evs [3] = '{EV_RISE, EV_FALL, EV_BOTH};
  int error_cnt = 0, compares = 0, cyc = 0;
  gtm_general_timer #(.RTC_DIVIDE(4)) gtm_general_timer_i (.aclk(aclk), .aresetn(aresetn),
    .ce(ce), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .capture_compare_pin(pin), .debug_halt(halt), .timer_irq(irq),
    .adc_trigger(adc));
  gtm_pin_model gtm_pin_model_i (.aclk(aclk), .pin(pin));
  // ======
  // clock, timeout, trigger spacing
  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    gap <= adc ? 32'h1 : gap + 32'h1;
    if (adc) adc_n <= adc_n + 32'h1;
    if (adc) last_gap <= gap;
    if (cyc == 20000) begin
      error_cnt++;
      close_out;
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY,
                    input logic [3:0] s = STRB_FULL);
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1;
    wv <= 1;
    br <= 1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 0;
      if (wrdy) wv <= 0;
      if (bv && br) begin
        br <= 0;
        chk(32'(bresp), 32'(er));
      end
    end while (awv || wv || br);
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] er = RESP_OKAY);
    ara <= a;
    arv <= 1;
    rr <= 1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 0;
      if (rv && rr) begin
        rdat = rdata;
        rr <= 0;
        chk(32'(rresp), 32'(er));
      end
    end while (arv || rr);
    @(posedge aclk);
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdat, e);
  endtask : rc
  task automatic fin(input string s);
    $display("test %s done", s);
  endtask : fin
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  // ======
  // tests
  initial begin
    {aresetn, awv, wv, br, arv, rr, halt, awa, ara, wd} = '0;
    ce = 1;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rc(OFS_COUNT_A, 32'hFFFF_FFFF);
    rc(OFS_LOAD_B, 32'h0000_FFFF);
    rc(OFS_CONTROL, 32'h0);
    wr(8'h44, 32'h1, RESP_SLVERR);
    rd(8'h40, RESP_SLVERR);
    chk(rdat, 32'h0);
    fin("reset");
    // half B left periodic: the joined counter must ignore it
    wr(OFS_MODE_B, 32'h2);
    wr(OFS_MODE_A, 32'h1);
    wr(OFS_LOAD_A, 32'h0002_0030);
    wr(OFS_LOAD_A, 32'h0009_0030, RESP_OKAY, 4'h3);
    rc(OFS_LOAD_B, 32'h2);
    wr(OFS_LOAD_A, 32'h30);
    wr(OFS_MASK, 32'h1);
    wr(OFS_CONTROL, 32'h11);
    do rd(OFS_RAW); while (rdat[0] !== 1'b1);
    rc(OFS_COUNT_A, 32'h30);
    rc(OFS_CONTROL, 32'h10);
    rc(OFS_MASKED, 32'h1);
    chk(adc_n, 32'h1);
    chk(32'(irq), 32'h1);
    wr(OFS_CLEAR, 32'h1);
    rc(OFS_RAW, 32'h0);
    chk(32'(irq), 32'h0);
    wr(OFS_MODE_A, 32'h2);
    wr(OFS_LOAD_A, 32'h1000);
    wr(OFS_CONTROL, 32'h3);
    wr(OFS_LOAD_A, 32'h20);
    rd(OFS_COUNT_A);
    chk(32'(rdat <= 32'h20), 32'h1);
    halt <= 1'b1;
    rd(OFS_COUNT_A);
    v = rdat;
    rc(OFS_COUNT_A, v);
    halt <= 1'b0;
    do rd(OFS_RAW); while (rdat[0] !== 1'b1);
    rc(OFS_CONTROL, 32'h3);
    fin("joined");
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_CLEAR, 32'hFFFF_FFFF);
    wr(OFS_CONFIG, 32'h1);
    wr(OFS_MATCH_A, 32'h2);
    wr(OFS_MASK, 32'h8);
    halt <= 1'b1;
    wr(OFS_CONTROL, 32'h243);
    rc(OFS_COUNT_A, 32'h1);
    gtm_pin_model_i.rtc(8);
    rc(OFS_COUNT_A, 32'h0);
    rc(OFS_RAW, 32'h8);
    chk(32'(irq), 32'h1);
    gtm_pin_model_i.rtc(4);
    rc(OFS_COUNT_A, 32'h1);
    wr(OFS_CLEAR, 32'h8);
    rc(OFS_MASKED, 32'h0);
    halt <= 1'b0;
    fin("clock");
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_CLEAR, 32'hFFFF_FFFF);
    wr(OFS_CONFIG, 32'h4);
    wr(OFS_MODE_A, 32'h1);
    wr(OFS_LOAD_A, 32'h5);
    wr(OFS_LOAD_B, 32'h3);
    wr(OFS_PRESCALE_B, 32'h2);
    v = adc_n;
    wr(OFS_CONTROL, 32'h1101);
    while (adc_n < v + 32'h3) @(posedge aclk);
    chk(last_gap, 32'hC);
    rc(OFS_COUNT_A, 32'h5);
    rc(OFS_CONTROL, 32'h1100);
    rc(OFS_RAW, 32'h101);
    fin("split");
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_CLEAR, 32'hFFFF_FFFF);
    wr(OFS_MODE_B, 32'h3);
    wr(OFS_MATCH_B, 32'h0);
    foreach (evs[i]) begin
      wr(OFS_LOAD_B, 32'hA);
      wr(OFS_CONTROL, 32'h100 | (32'(evs[i]) << 10));
      gtm_pin_model_i.edges(4, 1);
      rc(OFS_COUNT_B, 32'hA - ((evs[i] == EV_BOTH) ? 32'h4 : 32'h2));
    end
    wr(OFS_LOAD_B, 32'hA);
    wr(OFS_MATCH_B, 32'h6);
    wr(OFS_MASK, 32'h200);
    wr(OFS_CONTROL, 32'hD00);
    gtm_pin_model_i.edges(3, 1);
    rc(OFS_COUNT_B, 32'h7);
    gtm_pin_model_i.edges(3, 1);
    rc(OFS_COUNT_B, 32'hA);
    rc(OFS_CONTROL, 32'hC00);
    rc(OFS_MASKED, 32'h200);
    fin("edges");
    close_out;
  end
endmodule : tb_general_timer_counting_modes
